// >>> core/fuel_pulse_scheduler.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`include "fuel_pulse_regs.svh"

// How it works
// [R01] Every injector pulse is a whole number of 64 us ticks.
// [R02] A map entry is a tick count; base pulse is count times tick.
// [R03] Total pulse is map ticks plus injector opening ticks.
// [R04] Each injector output fires once per crank revolution; the secondary skips it when staged below staging speed.
// [R05] Two fuel maps; software switches the active one at any time.
// [R06] Speed, load and entry indices come from sites and read live.
// [R07] Enrichment triggers when throttle rise per window exceeds threshold.
// [R08] Active enrichment adds programmed extra ticks to every pulse.
// [R09] Enrichment lasts programmed revolutions, then idles until retriggered.
// [R10] Status bit shows accelerating while enrichment runs, else constant speed.
// [R11] Non-volatile save is requested only on explicit save command.
// [R12] Staging: primary always fires, secondary only at or above staging speed.
// [R13] Opening time comes from a table indexed by supply voltage.
// [R14] With staging, secondary pulse stays zero below activation speed.
// [R15] Pulse counter counts ticks down, output held until zero.
module fuel_pulse_scheduler #(
  parameter int TICK_CYC = `FPS_TICK_US * `FPS_CLK_MHZ,
  parameter int RATE_CYC = `FPS_RATE_US * `FPS_CLK_MHZ
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        crank_i,
  input  wire logic [15:0] rpm_i,
  input  wire logic [7:0]  load_i,
  input  wire logic [7:0]  tps_i,
  input  wire logic [7:0]  vsup_i,
  output logic      [1:0]  inj_o,
  output logic             accel_o,
  output logic             nv_save_o,
  output logic             irq_o
);

  // Reload values must fit the 16 and 20 bit counters
  if (TICK_CYC < 2 || TICK_CYC > 65536) begin : g_tick_chk
    $error("TICK_CYC out of range");
  end
  if (RATE_CYC < 2 || RATE_CYC > 1048576) begin : g_rate_chk
    $error("RATE_CYC out of range");
  end

  localparam logic [15:0] TICK_LD = 16'(TICK_CYC - 1);
  localparam logic [19:0] RATE_LD = 20'(RATE_CYC - 1);

  fuel_pulse_pkg::state_s s_q;
  fuel_pulse_pkg::state_s s_d;

  // Tables: two maps of 12 load x 16 speed, then sites and opening times
  logic [7:0]  map_mem  [0:383];
  logic [15:0] spd_site [0:15];
  logic [7:0]  load_site[0:11];
  logic [7:0]  open_mem [0:12];

  logic        wr_acc;
  logic        rd_acc;
  logic        tab_we;
  logic        rev;
  logic        tick;
  logic        active;
  logic        trig;
  logic [3:0]  sp_idx;
  logic [3:0]  ld_idx;
  logic [3:0]  v_idx;
  logic [8:0]  maddr;
  logic [16:0] total;
  logic [3:0]  ev;
  logic [7:0]  vdiff;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `FPS_A_IMASK);
  endfunction : mapped

  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign rd_acc    = psel_i & penable_i & ~pwrite_i;
  assign tab_we    = wr_acc && (paddr_i == `FPS_A_TDATA) && (s_q.taddr < `FPS_TB_END);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);
  assign prdata_o  = s_q.prdata;
  assign inj_o     = s_q.inj;
  assign nv_save_o = s_q.nv_save;
  assign active    = s_q.acc_cnt != 8'h00;
  assign accel_o   = active; // [R10]
  assign irq_o     = |(s_q.int_stat & s_q.int_mask);

  // Crank edge read only from the second and third stages
  assign rev  = s_q.crank_sy[1] & ~s_q.crank_sy[2]; // [R04]
  assign tick = s_q.tick_cnt == 16'h0000;

  // Site search on synchronised inputs
  always_comb begin
    sp_idx = 4'h0;
    ld_idx = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (s_q.rpm_s >= spd_site[i]) sp_idx = 4'(i); // [R06]
    end
    for (int i = 1; i < 12; i++) begin
      if (s_q.load_s >= load_site[i]) ld_idx = 4'(i); // [R06]
    end
  end

  // Supply clamped to the 5 V .. 17 V table span
  assign vdiff = s_q.vsup_s - 8'h05;
  assign v_idx = (s_q.vsup_s < 8'h05) ? 4'h0 : (vdiff > 8'h0C) ? 4'hC : vdiff[3:0]; // [R13]

  assign maddr = (s_q.map_sel ? 9'h0C0 : 9'h000) + {1'b0, s_q.load_idx, s_q.speed_idx}; // [R05]
  assign total = 17'(map_mem[maddr]) + 17'(open_mem[v_idx])
               + (active ? 17'(s_q.enr) : 17'h0_0000); // [R02] [R03] [R08]

  assign trig = (s_q.rate_cnt == 20'h0_0000) && (s_q.tps_s > s_q.tps_last)
              && ((s_q.tps_s - s_q.tps_last) > s_q.thr); // [R07]

  // Table writes kept apart so the arrays stay memories
  always_ff @(posedge mclk_i) begin
    if (tab_we) begin
      if (s_q.taddr < `FPS_TB_SPD) begin
        map_mem[s_q.taddr] <= pwdata_i[7:0];
      end else if (s_q.taddr < `FPS_TB_LOAD) begin
        spd_site[4'(s_q.taddr - `FPS_TB_SPD)] <= pwdata_i[15:0];
      end else if (s_q.taddr < `FPS_TB_OPEN) begin
        load_site[4'(s_q.taddr - `FPS_TB_LOAD)] <= pwdata_i[7:0];
      end else begin
        open_mem[4'(s_q.taddr - `FPS_TB_OPEN)] <= pwdata_i[7:0];
      end
    end
  end

  always_comb begin
    s_d         = s_q;
    s_d.nv_save = 1'b0;
    ev          = 4'h0;

    s_d.crank_sy = {s_q.crank_sy[1:0], crank_i};
    s_d.tps_m    = tps_i;
    s_d.tps_s    = s_q.tps_m;
    s_d.rpm_m    = rpm_i;
    s_d.rpm_s    = s_q.rpm_m;
    s_d.load_m   = load_i;
    s_d.load_s   = s_q.load_m;
    s_d.vsup_m   = vsup_i;
    s_d.vsup_s   = s_q.vsup_m;

    s_d.speed_idx = sp_idx;
    s_d.load_idx  = ld_idx;
    s_d.entry     = maddr;

    // Register writes
    if (wr_acc) begin
      unique case (paddr_i)
        `FPS_A_CTRL: begin
          s_d.map_sel  = pwdata_i[`FPS_CTRL_MAP];
          s_d.stage_en = pwdata_i[`FPS_CTRL_STG];
          s_d.nv_save  = pwdata_i[`FPS_CTRL_SAVE]; // [R11]
          if (pwdata_i[`FPS_CTRL_SAVE]) ev[`FPS_EV_SAVE] = 1'b1;
        end
        `FPS_A_THR:   s_d.thr       = pwdata_i[7:0];
        `FPS_A_ENR:   s_d.enr       = pwdata_i[15:0];
        `FPS_A_REVS:  s_d.revs      = pwdata_i[7:0];
        `FPS_A_STAGE: s_d.stage_rpm = pwdata_i[15:0];
        `FPS_A_TADDR: s_d.taddr     = pwdata_i[8:0];
        `FPS_A_TDATA: if (tab_we) s_d.taddr = s_q.taddr + 9'h001;
        `FPS_A_IMASK: s_d.int_mask  = pwdata_i[3:0];
        default: ;
      endcase
    end

    // Read data prepared in the setup cycle
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        `FPS_A_CTRL:   s_d.prdata = {30'h0, s_q.stage_en, s_q.map_sel};
        `FPS_A_THR:    s_d.prdata = {24'h00_0000, s_q.thr};
        `FPS_A_ENR:    s_d.prdata = {16'h0000, s_q.enr};
        `FPS_A_REVS:   s_d.prdata = {24'h00_0000, s_q.revs};
        `FPS_A_STAGE:  s_d.prdata = {16'h0000, s_q.stage_rpm};
        `FPS_A_TADDR:  s_d.prdata = {23'h0, s_q.taddr};
        `FPS_A_STATUS: s_d.prdata = {3'h0, s_q.acc_cnt, s_q.entry, s_q.load_idx, s_q.speed_idx,
                                     1'h0, s_q.inj, active}; // [R06] [R10]
        `FPS_A_ISTAT:  s_d.prdata = {28'h000_0000, s_q.int_stat};
        `FPS_A_IMASK:  s_d.prdata = {28'h000_0000, s_q.int_mask};
        default:       s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Throttle rate window
    if (s_q.rate_cnt == 20'h0_0000) begin
      s_d.rate_cnt = RATE_LD;
      s_d.tps_last = s_q.tps_s;
    end else begin
      s_d.rate_cnt = s_q.rate_cnt - 20'h0_0001;
    end

    // Enrichment: sampled at the revolution before the count steps
    if (trig) begin
      s_d.acc_cnt       = s_q.revs; // [R07] [R09]
      ev[`FPS_EV_TRIG]  = 1'b1;
    end else if (rev && active) begin
      s_d.acc_cnt = s_q.acc_cnt - 8'h01; // [R09]
      if (s_q.acc_cnt == 8'h01) ev[`FPS_EV_END] = 1'b1;
    end

    // Pulse timing; tick restarts on each revolution so lengths stay whole ticks
    if (rev) begin
      s_d.tick_cnt = TICK_LD; // [R01]
      if (s_q.pul != 34'h0_0000_0000) ev[`FPS_EV_OVR] = 1'b1;
      s_d.pul[16:0] = total; // [R04]
      if (s_q.stage_en && (s_q.rpm_s < s_q.stage_rpm)) begin
        s_d.pul[33:17] = 17'h0_0000; // [R12] [R14]
      end else begin
        s_d.pul[33:17] = total; // [R12]
      end
    end else begin
      s_d.tick_cnt = tick ? TICK_LD : s_q.tick_cnt - 16'h0001; // [R01]
      for (int c = 0; c < 2; c++) begin
        if (tick && s_q.pul[c*17 +: 17] != 17'h0_0000) begin
          s_d.pul[c*17 +: 17] = s_q.pul[c*17 +: 17] - 17'h0_0001; // [R15]
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      s_d.inj[c] = s_d.pul[c*17 +: 17] != 17'h0_0000; // [R15]
    end

    // Clear only bits captured at setup; events since then survive
    s_d.int_stat = (s_q.int_stat & ~((rd_acc && paddr_i == `FPS_A_ISTAT) ? s_q.prdata[3:0] : 4'h0)) | ev;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.thr       <= `FPS_RST_THR;
      s_q.enr       <= `FPS_RST_ENR;
      s_q.revs      <= `FPS_RST_REVS;
      s_q.stage_rpm <= `FPS_RST_STAGE;
      s_q.tick_cnt  <= TICK_LD;
      s_q.rate_cnt  <= RATE_LD;
    end else begin
      s_q <= s_d;
    end
  end

  property p_tick_reload;
    @(posedge mclk_i) disable iff (rst_i)
      (tick && !rev) |=> (s_q.tick_cnt == TICK_LD);
  endproperty
  a_tick_reload: assert property (p_tick_reload) else $error("tick not reloaded"); // [R01]

  property p_total;
    @(posedge mclk_i) disable iff (rst_i)
      rev |=> (s_q.pul[16:0] == $past(total)) && inj_o[0] == ($past(total) != 17'h0_0000);
  endproperty
  a_total: assert property (p_total) else $error("pulse load wrong"); // [R02] [R03] [R08]

  property p_step;
    @(posedge mclk_i) disable iff (rst_i)
      (tick && !rev && s_q.pul[16:0] != 17'h0_0000) |=> (s_q.pul[16:0] == $past(s_q.pul[16:0]) - 17'h0_0001);
  endproperty
  a_step: assert property (p_step) else $error("pulse countdown wrong"); // [R15]

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (!rev && !tick && s_q.pul[16:0] != 17'h0_0000) |=> inj_o[0] && $stable(s_q.pul[16:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("pulse dropped between ticks"); // [R15]

  property p_once;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(inj_o[0]) |-> $past(rev);
  endproperty
  a_once: assert property (p_once) else $error("injector fired without revolution"); // [R04]

  property p_stage;
    @(posedge mclk_i) disable iff (rst_i)
      (rev && s_q.stage_en && s_q.rpm_s < s_q.stage_rpm) |=> !inj_o[1];
  endproperty
  a_stage: assert property (p_stage) else $error("secondary fired below staging speed"); // [R12] [R14]

  property p_trig;
    @(posedge mclk_i) disable iff (rst_i)
      trig |=> (s_q.acc_cnt == $past(s_q.revs)) && s_q.int_stat[`FPS_EV_TRIG];
  endproperty
  a_trig: assert property (p_trig) else $error("enrichment not armed"); // [R07] [R10]

  property p_end;
    @(posedge mclk_i) disable iff (rst_i)
      (rev && !trig && s_q.acc_cnt == 8'h01) |=> !accel_o && s_q.int_stat[`FPS_EV_END];
  endproperty
  a_end: assert property (p_end) else $error("enrichment did not end"); // [R09]

  property p_save;
    @(posedge mclk_i) disable iff (rst_i)
      nv_save_o |-> $past(wr_acc && paddr_i == `FPS_A_CTRL && pwdata_i[`FPS_CTRL_SAVE]);
  endproperty
  a_save: assert property (p_save) else $error("save without command"); // [R11]

  property p_sticky;
    @(posedge mclk_i) disable iff (rst_i)
      (ev != 4'h0) |=> ((s_q.int_stat & $past(ev)) == $past(ev));
  endproperty
  a_sticky: assert property (p_sticky) else $error("event lost"); // [R07] [R09]

  property p_clear;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_acc && paddr_i == `FPS_A_ISTAT && ev == 4'h0) |=> ((s_q.int_stat & $past(s_q.prdata[3:0])) == 4'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("read bits not cleared"); // [R07] [R09]

  property p_sec_mirror;
    @(posedge mclk_i) disable iff (rst_i)
      (rev && !(s_q.stage_en && s_q.rpm_s < s_q.stage_rpm)) |=> (s_q.pul[33:17] == $past(total));
  endproperty
  a_sec_mirror: assert property (p_sec_mirror) else $error("secondary load wrong"); // [R12]

  property p_vclamp;
    @(posedge mclk_i) disable iff (rst_i)
      v_idx <= 4'hC;
  endproperty
  a_vclamp: assert property (p_vclamp) else $error("opening index outside table"); // [R13]

  property p_acc_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (!trig && !rev) |=> $stable(s_q.acc_cnt);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("enrichment count moved"); // [R09]

  property p_sync;
    @(posedge mclk_i) disable iff (rst_i)
      rev |-> ($past(crank_i, 2) && !$past(crank_i, 3));
  endproperty
  a_sync: assert property (p_sync) else $error("revolution without crank edge"); // [R04]

  property p_ovr;
    @(posedge mclk_i) disable iff (rst_i)
      (rev && s_q.pul != 34'h0_0000_0000) |=> s_q.int_stat[`FPS_EV_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // [R04]

endmodule : fuel_pulse_scheduler

// >>> inc/fuel_pulse_pkg.sv
package fuel_pulse_pkg;

  typedef struct packed {
    logic [31:0] prdata;
    logic        map_sel;
    logic        stage_en;
    logic [7:0]  thr;
    logic [15:0] enr;
    logic [7:0]  revs;
    logic [15:0] stage_rpm;
    logic [8:0]  taddr;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [2:0]  crank_sy;
    logic [7:0]  tps_m;
    logic [7:0]  tps_s;
    logic [15:0] rpm_m;
    logic [15:0] rpm_s;
    logic [7:0]  load_m;
    logic [7:0]  load_s;
    logic [7:0]  vsup_m;
    logic [7:0]  vsup_s;
    logic [7:0]  tps_last;
    logic [19:0] rate_cnt;
    logic [7:0]  acc_cnt;
    logic [15:0] tick_cnt;
    logic [33:0] pul;
    logic [1:0]  inj;
    logic        nv_save;
    logic [3:0]  speed_idx;
    logic [3:0]  load_idx;
    logic [8:0]  entry;
  } state_s;

endpackage : fuel_pulse_pkg

// >>> inc/fuel_pulse_regs.svh
`ifndef FUEL_PULSE_REGS_SVH
`define FUEL_PULSE_REGS_SVH

// Timing
`define FPS_CLK_MHZ   100
`define FPS_TICK_US   64
`define FPS_RATE_US   10000

// Register byte offsets
`define FPS_A_CTRL    8'h00
`define FPS_A_THR     8'h04
`define FPS_A_ENR     8'h08
`define FPS_A_REVS    8'h0C
`define FPS_A_STAGE   8'h10
`define FPS_A_TADDR   8'h14
`define FPS_A_TDATA   8'h18
`define FPS_A_STATUS  8'h1C
`define FPS_A_ISTAT   8'h20
`define FPS_A_IMASK   8'h24

// Control fields
`define FPS_CTRL_MAP  0
`define FPS_CTRL_STG  1
`define FPS_CTRL_SAVE 2

// Interrupt bits
`define FPS_EV_TRIG   0
`define FPS_EV_END    1
`define FPS_EV_SAVE   2
`define FPS_EV_OVR    3

// Table space behind TADDR/TDATA
`define FPS_TB_SPD    9'h180
`define FPS_TB_LOAD   9'h190
`define FPS_TB_OPEN   9'h19C
`define FPS_TB_END    9'h1A9

// Reset values
`define FPS_RST_THR   8'h14
`define FPS_RST_ENR   16'h0020
`define FPS_RST_REVS  8'h28
`define FPS_RST_STAGE 16'h0FA0

`endif

// >>> testbench/engine_model.sv
`timescale 1ns/1ns
module engine_model (
  input  wire logic        mclk_i,
  input  wire logic        fire_i,
  input  wire logic [1:0]  inj_i,
  output logic             crank_o,
  output logic      [15:0] w0_o,
  output logic      [15:0] w1_o
);
  logic [3:0] hold_q = 4'h0;
  // One rising edge per revolution, held long enough for the syncs
  assign crank_o = (hold_q != 4'h0);
  initial begin
    w0_o = 16'h0000;
    w1_o = 16'h0000;
  end
  always @(posedge mclk_i) begin
    if (fire_i) begin
      hold_q <= 4'hF;
      w0_o   <= 16'h0000;
      w1_o   <= 16'h0000;
    end else begin
      if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
      // Width in clocks; bench scales by the tick
      w0_o <= w0_o + {15'h0000, inj_i[0]};
      w1_o <= w1_o + {15'h0000, inj_i[1]};
    end
  end
endmodule : engine_model

// >>> testbench/fuel_pulse_scheduler_tb.sv
`timescale 1ns/1ns
`include "fuel_pulse_regs.svh"
module fuel_pulse_scheduler_tb;
  localparam int TK = 4;
  logic        mclk_i    = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [15:0] rpm_i     = 16'h03E8;
  logic [7:0]  load_i    = 8'h0A;
  logic [7:0]  tps_i     = 8'h00;
  logic [7:0]  vsup_i    = 8'h0C;
  logic        fire      = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        crank_i;
  logic [1:0]  inj_o;
  logic        accel_o;
  logic        nv_save_o;
  logic        irq_o;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [31:0] rv;
  logic        er;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          n_save      = 0;
  // Rows: map, staging, rpm, volts, primary ticks, secondary ticks
  logic [47:0] rows [4] = '{48'h0003_E80C_0D0D, 48'h1003_E805_0A0A, 48'h010B_B811_1200, 48'h1113_8803_0A0A};

  fuel_pulse_scheduler #(.TICK_CYC(TK), .RATE_CYC(50)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .crank_i(crank_i), .rpm_i(rpm_i), .load_i(load_i),
    .tps_i(tps_i), .vsup_i(vsup_i), .inj_o(inj_o), .accel_o(accel_o), .nv_save_o(nv_save_o), .irq_o(irq_o));
  engine_model em (.mclk_i(mclk_i), .fire_i(fire), .inj_i(inj_o), .crank_o(crank_i), .w0_o(w0), .w1_o(w1));

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) n_save <= n_save + int'(nv_save_o === 1'b1);

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Caller sits just after an edge; release then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    rv = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  // Pulse ends well inside the wait: longest is 18 ticks
  task automatic rev(input int t0, input int t1);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    repeat (110) @(posedge mclk_i);
    chk("pulse_primary", t0 * TK, {16'h0000, w0});
    chk("pulse_secondary", t1 * TK, {16'h0000, w1});
  endtask : rev

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk("inj_reset", 0, {30'h0, inj_o});
    apb(0, `FPS_A_THR, 0);
    chk("thr_reset", 32'h0000_0014, rv);
    apb(0, `FPS_A_STAGE, 0);
    chk("stage_reset", 32'h0000_0FA0, rv);
    // Uniform maps so site edges cannot blur the expected ticks
    apb(1, `FPS_A_TADDR, 0);
    for (int i = 0; i < `FPS_TB_END; i++) begin
      apb(1, `FPS_A_TDATA, i < 9'h0C0 ? 5 : i < `FPS_TB_SPD ? 9 : i < `FPS_TB_LOAD ? (i - `FPS_TB_SPD) * 500 :
        i < `FPS_TB_OPEN ? (i - `FPS_TB_LOAD) * 20 : i - 9'h19B);
    end
    // Pointer past the table: write ignored, pointer stays
    apb(1, `FPS_A_TDATA, 99);
    apb(0, `FPS_A_TADDR, 0);
    chk("taddr_stop", 32'h0000_01A9, rv);
    chk("mapped_err", 0, er);
    foreach (rows[j]) begin
      rpm_i  <= rows[j][39:24];
      vsup_i <= rows[j][23:16];
      apb(1, `FPS_A_CTRL, {30'h0, rows[j][40], rows[j][44]});
      repeat (10) @(posedge mclk_i);
      rev(rows[j][15:8], rows[j][7:0]);
    end
    rpm_i  <= 16'h03E8;
    vsup_i <= 8'h0C;
    apb(1, `FPS_A_CTRL, 0);
    apb(1, `FPS_A_THR, 40);
    apb(1, `FPS_A_ENR, 3);
    apb(1, `FPS_A_REVS, 2);
    apb(1, `FPS_A_IMASK, 3);
    apb(0, `FPS_A_ISTAT, 0);
    tps_i <= 8'h1E;
    repeat (120) @(posedge mclk_i);
    chk("accel_high_thr", 0, accel_o);
    apb(1, `FPS_A_THR, 10);
    tps_i <= 8'h3C;
    repeat (120) @(posedge mclk_i);
    chk("accel_low_thr", 1, accel_o);
    chk("irq_raised", 1, irq_o);
    apb(0, `FPS_A_STATUS, 0);
    chk("status_accel", 1, rv[0]);
    chk("status_idx", 32'h0000_0202, {15'h0000, rv[20:4]});
    chk("status_acc", 2, rv[28:21]);
    rev(16, 16);
    rev(16, 16);
    chk("accel_end", 0, accel_o);
    rev(13, 13);
    apb(0, `FPS_A_ISTAT, 0);
    chk("istat_enrich", 3, rv[3:0]);
    chk("irq_cleared", 0, irq_o);
    chk("save_idle", 0, n_save);
    apb(1, `FPS_A_CTRL, 4);
    @(posedge mclk_i);
    chk("save_pulse", 1, n_save);
    chk("irq_masked", 0, irq_o);
    apb(0, `FPS_A_ISTAT, 0);
    chk("istat_save", 4, rv[3:0]);
    apb(0, 8'h28, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rv);
    // Reset in mid pulse; held until the crank pin is low again
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk("inj_before_reset", 3, {30'h0, inj_o});
    rst_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk("inj_midreset", 0, {30'h0, inj_o});
    chk("irq_midreset", 0, irq_o);
    apb(0, `FPS_A_THR, 0);
    chk("thr_midreset", 32'h0000_0014, rv);
    complete_run();
  end
endmodule : fuel_pulse_scheduler_tb
